/* verilog/cbx_pkg.sv */
// Shared constants and types for the conditional branch execute unit
package cbx_pkg;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned IMM_W = 16;
   localparam int unsigned REG_IDX_W = 5;
   localparam int unsigned COND_W = 4;
   // Instruction fields, bit 0 is the word's most significant bit
   localparam int unsigned DELAY_BIT = 6;
   localparam int unsigned COND_MSB = 7;
   localparam int unsigned SRC_MSB = 11;
   localparam int unsigned OFS_MSB = 16;
   localparam int unsigned IMM_MSB = 16;
   // Major opcode fields
   localparam logic [5:0] OPC_BCC_REG = 6'h27;
   localparam logic [5:0] OPC_BCC_IMM = 6'h2F;
   localparam logic [5:0] OPC_IMM_PREFIX = 6'h2C;
   // Condition codes handled here
   localparam logic [COND_W-1:0] COND_NE = 4'h1;
   localparam logic [COND_W-1:0] COND_LT = 4'h2;
   localparam logic [COND_W-1:0] COND_LE = 4'h3;
   localparam logic [COND_W-1:0] COND_GT = 4'h4;
   localparam logic [DATA_W-1:0] PC_STEP = 32'h0000_0004;
   localparam logic [DATA_W-1:0] PC_RESET = 32'h0000_0000;
   // Cycle costs
   localparam logic [1:0] LAT_NOT_TAKEN = 2'h1;
   localparam logic [1:0] LAT_TAKEN_DELAY = 2'h2;
   localparam logic [1:0] LAT_TAKEN_NODELAY = 2'h3;
   typedef enum logic [1:0] {CBX_IDLE, CBX_BUSY} cbx_state_t;
endpackage : cbx_pkg

/* verilog/cbx_imm_unit.sv */
// Immediate builder: sign extension or prefix-widened 32-bit operand
module cbx_imm_unit (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   // Instruction stream
   input wire logic i_issue,
   input wire logic [cbx_pkg::DATA_W-1:0] i_instr,
   // Operand
   output logic [cbx_pkg::DATA_W-1:0] o_imm
);
   logic prefix_valid;
   logic [cbx_pkg::IMM_W-1:0] prefix_high;
   wire logic [cbx_pkg::IMM_W-1:0] imm_field = i_instr[cbx_pkg::IMM_W-1:0];
   wire logic is_prefix = i_instr[31:26] == cbx_pkg::OPC_IMM_PREFIX;

   assign o_imm = prefix_valid ? {prefix_high, imm_field}
                               : {{cbx_pkg::IMM_W{imm_field[cbx_pkg::IMM_W-1]}}, imm_field};

   // Prefix only covers the instruction issued right after it
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         prefix_valid <= 1'b0;
         prefix_high <= 16'h0000;
      end else if (i_issue) begin
         prefix_valid <= is_prefix;
         prefix_high <= imm_field;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Checks
   property p_sext;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      !prefix_valid |-> $signed(o_imm) == $signed(imm_field);
   endproperty
   a_sext: assert property (p_sext) else $error("immediate not sign-extended");
   property p_prefix_widen;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_issue && is_prefix |=> prefix_valid && o_imm == {$past(imm_field), imm_field};
   endproperty
   a_prefix_widen: assert property (p_prefix_widen) else $error("prefix not applied");
   property p_prefix_clears;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_issue && !is_prefix |=> !prefix_valid;
   endproperty
   a_prefix_clears: assert property (p_prefix_clears) else $error("prefix outlived its successor");
endmodule : cbx_imm_unit

/* verilog/cbx_branch_unit.sv */
// Conditional branch decode and execute: condition, target, delay slot, cycle cost
// Functional notes
// - Greater-than branches are taken only when the signed tested register is above zero.
// - Less-or-equal branches are taken when the signed tested register is zero or negative.
// - Less-than branches are taken only when the signed tested register is negative.
// - Not-equal branches are taken whenever the tested register is nonzero.
// - A taken register-offset branch loads PC with its own address plus the offset register.
// - A taken immediate-offset branch loads PC with its own address plus the extended immediate.
// - A failed condition advances PC by four.
// - A taken branch with delay flag lets the next sequential instruction complete first.
// - A taken branch without delay flag discards the sequential successor.
// - A failed branch completes in one cycle regardless of the delay flag.
// - A taken branch with delay flag costs two cycles.
// - A taken branch without delay flag costs three cycles.
// - Register-immediate operands are the 16-bit field sign-extended to 32 bits.
// - After an upper-half prefix the prefix value and the 16-bit field form the immediate.
module cbx_branch_unit (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   // Fetch stage: instruction and its address
   input wire logic i_issue,
   input wire logic [cbx_pkg::DATA_W-1:0] i_instr,
   input wire logic [cbx_pkg::DATA_W-1:0] i_instr_pc,
   // Register file read ports
   output logic [cbx_pkg::REG_IDX_W-1:0] o_tested_source_idx,
   output logic [cbx_pkg::REG_IDX_W-1:0] o_offset_source_idx,
   input wire logic [cbx_pkg::DATA_W-1:0] i_tested_source_reg,
   input wire logic [cbx_pkg::DATA_W-1:0] i_offset_source_reg,
   // Results toward fetch
   output logic o_busy,
   output logic o_pc_load,
   output logic [cbx_pkg::DATA_W-1:0] o_next_pc,
   output logic o_branch_taken,
   output logic o_flush_successor,
   output logic o_delay_slot,
   output logic [1:0] o_cycles,
   output logic o_reg_write
);
   ////////////////////////////////////////////////////////////////
   // Decode
   wire logic [5:0] opcode = i_instr[31:26];
   wire logic delay_flag = i_instr[31-cbx_pkg::DELAY_BIT];
   wire logic [cbx_pkg::COND_W-1:0] cond =
      i_instr[31-cbx_pkg::COND_MSB -: cbx_pkg::COND_W];
   wire logic is_reg_form = opcode == cbx_pkg::OPC_BCC_REG;
   wire logic is_imm_form = opcode == cbx_pkg::OPC_BCC_IMM;
   wire logic cond_known = cond == cbx_pkg::COND_NE || cond == cbx_pkg::COND_LT
                           || cond == cbx_pkg::COND_LE || cond == cbx_pkg::COND_GT;
   wire logic is_branch = (is_reg_form || is_imm_form) && cond_known;
   wire logic [cbx_pkg::DATA_W-1:0] imm_value;

   assign o_tested_source_idx = i_instr[31-cbx_pkg::SRC_MSB -: cbx_pkg::REG_IDX_W];
   assign o_offset_source_idx = i_instr[31-cbx_pkg::OFS_MSB -: cbx_pkg::REG_IDX_W];

   // Stall cycles re-offer the branch; gating keeps a pending prefix intact
   cbx_imm_unit u_imm (
      .i_ref_clk(i_ref_clk),
      .i_arst_n(i_arst_n),
      .i_issue(i_issue && !o_busy),
      .i_instr(i_instr),
      .o_imm(imm_value)
   );

   ////////////////////////////////////////////////////////////////
   // Condition on the full signed word
   wire logic src_zero = i_tested_source_reg == 32'h0000_0000;
   wire logic src_neg = i_tested_source_reg[cbx_pkg::DATA_W-1];
   wire logic cond_true =
      (cond == cbx_pkg::COND_GT) ? (!src_neg && !src_zero) :
      (cond == cbx_pkg::COND_LE) ? (src_neg || src_zero) :
      (cond == cbx_pkg::COND_LT) ? src_neg :
      !src_zero;
   wire logic [cbx_pkg::DATA_W-1:0] offset = is_imm_form ? imm_value
                                                         : i_offset_source_reg;
   wire logic [cbx_pkg::DATA_W-1:0] next_target = i_instr_pc + offset;
   wire logic [cbx_pkg::DATA_W-1:0] next_seq = i_instr_pc + cbx_pkg::PC_STEP;
   wire logic accept = i_issue && !o_busy && is_branch;
   wire logic next_taken = accept && cond_true;
   wire logic [1:0] next_cycles = !cond_true ? cbx_pkg::LAT_NOT_TAKEN :
                                  delay_flag ? cbx_pkg::LAT_TAKEN_DELAY :
                                  cbx_pkg::LAT_TAKEN_NODELAY;

   ////////////////////////////////////////////////////////////////
   // Result registers
   cbx_pkg::cbx_state_t state;
   logic [1:0] stall_left;

   assign o_busy = state == cbx_pkg::CBX_BUSY;
   assign o_reg_write = 1'b0;

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_pc_load <= 1'b0;
         o_next_pc <= cbx_pkg::PC_RESET;
         o_branch_taken <= 1'b0;
         o_flush_successor <= 1'b0;
         o_delay_slot <= 1'b0;
         o_cycles <= 2'h0;
      end else begin
         o_pc_load <= accept;
         o_branch_taken <= next_taken;
         o_flush_successor <= next_taken && !delay_flag;
         o_delay_slot <= next_taken && delay_flag;
         if (accept) begin
            o_next_pc <= cond_true ? next_target : next_seq;
            o_cycles <= next_cycles;
         end
      end
   end

   // Holds the unit busy for the extra cycles of a taken branch
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= cbx_pkg::CBX_IDLE;
         stall_left <= 2'h0;
      end else begin
         unique case (state)
            cbx_pkg::CBX_IDLE: begin
               if (next_taken) begin
                  state <= cbx_pkg::CBX_BUSY;
                  stall_left <= next_cycles - cbx_pkg::LAT_NOT_TAKEN;
               end
            end
            cbx_pkg::CBX_BUSY: begin
               stall_left <= stall_left - 2'h1;
               if (stall_left == 2'h1) begin
                  state <= cbx_pkg::CBX_IDLE;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // Checks
   property p_gt_cond;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      accept && cond == cbx_pkg::COND_GT |=>
         o_branch_taken == ($signed($past(i_tested_source_reg)) > 32'sh0000_0000);
   endproperty
   a_gt_cond: assert property (p_gt_cond) else $error("gt decision wrong");
   property p_le_cond;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      accept && cond == cbx_pkg::COND_LE |=>
         o_branch_taken == ($signed($past(i_tested_source_reg)) <= 32'sh0000_0000);
   endproperty
   a_le_cond: assert property (p_le_cond) else $error("le decision wrong");
   property p_lt_cond;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      accept && cond == cbx_pkg::COND_LT |=>
         o_branch_taken == ($signed($past(i_tested_source_reg)) < 32'sh0000_0000);
   endproperty
   a_lt_cond: assert property (p_lt_cond) else $error("lt decision wrong");
   property p_ne_cond;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      accept && cond == cbx_pkg::COND_NE |=>
         o_branch_taken == ($past(i_tested_source_reg) != 32'h0000_0000);
   endproperty
   a_ne_cond: assert property (p_ne_cond) else $error("ne decision wrong");
   property p_fall_through;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      accept && !cond_true |=> o_next_pc == $past(i_instr_pc) + 32'h0000_0004 && !o_busy;
   endproperty
   a_fall_through: assert property (p_fall_through) else $error("fall-through wrong");
   property p_taken_delay;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      next_taken && delay_flag |=> o_busy && o_delay_slot ##1 !o_busy;
   endproperty
   a_taken_delay: assert property (p_taken_delay) else $error("delay branch cost wrong");
   property p_taken_nodelay;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      next_taken && !delay_flag |=> o_busy && o_flush_successor ##1 o_busy ##1 !o_busy;
   endproperty
   a_taken_nodelay: assert property (p_taken_nodelay) else $error("no-delay branch cost wrong");
   property p_no_reg_write;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      o_pc_load |-> !o_reg_write;
   endproperty
   a_no_reg_write: assert property (p_no_reg_write) else $error("register written");

   ////////////////////////////////////////////////////////////////
   // Target, cost and refusal checks
   property p_reg_target;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      accept && cond_true && is_reg_form |=> o_next_pc == $past(i_instr_pc) + $past(i_offset_source_reg);
   endproperty
   a_reg_target: assert property (p_reg_target) else $error("register target wrong");
   property p_imm_target;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      accept && cond_true && is_imm_form |=> o_next_pc == $past(i_instr_pc) + $past(imm_value);
   endproperty
   a_imm_target: assert property (p_imm_target) else $error("immediate target wrong");
   property p_not_taken_cost;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      accept && !cond_true |=> o_cycles == cbx_pkg::LAT_NOT_TAKEN && !o_branch_taken && !o_flush_successor;
   endproperty
   a_not_taken_cost: assert property (p_not_taken_cost) else $error("not-taken cost wrong");
   property p_delay_outcome;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      next_taken && delay_flag |=> o_delay_slot && !o_flush_successor && o_cycles == cbx_pkg::LAT_TAKEN_DELAY;
   endproperty
   a_delay_outcome: assert property (p_delay_outcome) else $error("delay slot outcome wrong");
   property p_flush_outcome;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      next_taken && !delay_flag |=> o_flush_successor && !o_delay_slot && o_cycles == cbx_pkg::LAT_TAKEN_NODELAY;
   endproperty
   a_flush_outcome: assert property (p_flush_outcome) else $error("flush outcome wrong");
   // A re-offered branch during the stall must not execute twice
   property p_busy_refused;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      o_busy |=> !o_pc_load;
   endproperty
   a_busy_refused: assert property (p_busy_refused) else $error("issue accepted while busy");
   property p_non_branch_silent;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      i_issue && !o_busy && !is_branch |=> !o_pc_load;
   endproperty
   a_non_branch_silent: assert property (p_non_branch_silent) else $error("non-branch executed");
   property p_flags_with_load;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      o_flush_successor || o_delay_slot |-> o_branch_taken && o_pc_load;
   endproperty
   a_flags_with_load: assert property (p_flags_with_load) else $error("slot flag without taken load");
   property p_result_stands;
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      !accept |=> $stable(o_next_pc) && $stable(o_cycles);
   endproperty
   a_result_stands: assert property (p_result_stands) else $error("result changed without a branch");
endmodule : cbx_branch_unit

/* tb/cbx_regfile_model.sv */
// Register file model answering the tested and offset read ports
module cbx_regfile_model (
   // Read indices
   input wire logic [4:0] i_tested_idx,
   input wire logic [4:0] i_offset_idx,
   // Read values
   output logic [31:0] o_tested_val,
   output logic [31:0] o_offset_val
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem [32];
   // Register zero is hardwired, so the bench never relies on it
   assign o_tested_val = (i_tested_idx == 5'h00) ? 32'h0000_0000 : mem[i_tested_idx];
   assign o_offset_val = (i_offset_idx == 5'h00) ? 32'h0000_0000 : mem[i_offset_idx];
endmodule : cbx_regfile_model

/* tb/cond_branch_exec_unit_tb.sv */
// Self-checking bench for the conditional branch execute unit
module cond_branch_exec_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk;
   logic i_arst_n;
   logic i_issue;
   logic [31:0] i_instr;
   logic [31:0] i_instr_pc;
   logic [4:0] t_idx;
   logic [4:0] o_idx;
   logic [31:0] t_val;
   logic [31:0] o_val;
   logic o_busy, o_pc_load, o_branch_taken, o_flush_successor, o_delay_slot, o_reg_write;
   logic [31:0] o_next_pc;
   logic [1:0] o_cycles;
   logic [39:0] q [$];
   wire logic [39:0] act = {o_pc_load, o_reg_write, o_next_pc, o_cycles, o_branch_taken, o_flush_successor,
      o_delay_slot, o_busy};
   logic [31:0] x;
   logic [31:0] v;
   int n_mismatch = 0;
   int comparisons = 0;
   int cyc = 0;
   logic [3:0] cl [4] = '{cbx_pkg::COND_NE, cbx_pkg::COND_LT, cbx_pkg::COND_LE, cbx_pkg::COND_GT};
   logic [31:0] tvs [5] = '{32'h0000_0000, 32'h0000_0001, 32'hFFFF_FFFF, 32'h8000_0000, 32'h7FFF_FFFF};
   cbx_regfile_model rf (.i_tested_idx(t_idx), .i_offset_idx(o_idx), .o_tested_val(t_val), .o_offset_val(o_val));
   cbx_branch_unit uut (.i_ref_clk(clk), .i_arst_n(i_arst_n), .i_issue(i_issue), .i_instr(i_instr),
      .i_instr_pc(i_instr_pc), .o_tested_source_idx(t_idx), .o_offset_source_idx(o_idx),
      .i_tested_source_reg(t_val), .i_offset_source_reg(o_val), .o_busy(o_busy), .o_pc_load(o_pc_load),
      .o_next_pc(o_next_pc), .o_branch_taken(o_branch_taken), .o_flush_successor(o_flush_successor),
      .o_delay_slot(o_delay_slot), .o_cycles(o_cycles), .o_reg_write(o_reg_write));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [39:0] exp, input logic [39:0] act);
      comparisons++;
      if (act !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t exp %h got %h", $time, exp, act);
      end
   endtask : cmp
   task automatic summarize();
      if (q.size() != 0) n_mismatch++;
      $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : summarize
   // Issue one branch; a taken one keeps re-offering itself while busy, which must be ignored
   task automatic br(input logic [3:0] c, input logic fi, input logic d, input logic [31:0] tv,
      input logic [31:0] ofs);
      logic [4:0] tr;
      logic [4:0] orr;
      logic tk;
      logic [31:0] pc;
      tr = 5'($urandom_range(31, 1));
      orr = (tr == 5'h1F) ? 5'h01 : tr + 5'h01;
      pc = $urandom() & 32'hFFFF_FFFC;
      case (c)
         cbx_pkg::COND_NE: tk = (tv != 32'h0000_0000);
         cbx_pkg::COND_LT: tk = $signed(tv) < 0;
         cbx_pkg::COND_LE: tk = $signed(tv) <= 0;
         default: tk = $signed(tv) > 0;
      endcase
      rf.mem[tr] <= tv;
      rf.mem[orr] <= ofs;
      q.push_back({2'h2, tk ? pc + ofs : pc + 32'h0000_0004, tk ? (d ? 2'h2 : 2'h3) : 2'h1, tk, tk & ~d, tk & d, tk});
      i_issue <= 1'b1;
      i_instr <= {fi ? 6'h2F : 6'h27, d, c, tr, fi ? ofs[15:0] : {orr, 11'h000}};
      i_instr_pc <= pc;
      @(posedge clk);
      if (tk) repeat (d ? 1 : 2) @(posedge clk);
   endtask : br
   task automatic pre(input logic [15:0] hi);
      i_issue <= 1'b1;
      i_instr <= {6'h2C, 10'h000, hi};
      @(posedge clk);
   endtask : pre
   ////////////////////////////////////////////////////////////////////////////////
   always @(negedge clk) begin
      if (o_pc_load === 1'b1) begin
         if (q.size() == 0) cmp(40'h00_0000_0000, act);
         else cmp(q.pop_front(), act);
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         summarize();
      end
   end
   initial begin
      i_arst_n = 1'b0;
      i_issue = 1'b0;
      i_instr = 32'h0000_0000;
      i_instr_pc = 32'h0000_0000;
      void'($urandom(32'h4894));
      repeat (10) @(posedge clk);
      i_arst_n <= 1'b1;
      foreach (tvs[t]) begin
         for (int k = 0; k < 16; k++) begin
            x = $urandom();
            br(cl[k[3:2]], k[1], k[0], tvs[t], k[1] ? {{16{x[15]}}, x[15:0]} : x);
         end
      end
      for (int k = 0; k < 40; k++) begin
         x = $urandom();
         v = $urandom();
         pre(x[31:16]);
         br(cl[k % 4], 1'b1, k[0], v, x);
         br(cl[k % 4], k[2], k[1], v, k[2] ? {{16{x[15]}}, x[15:0]} : x);
      end
      // Equal-test encoding is outside this unit and must stay silent
      i_instr <= {6'h27, 1'b0, 4'h0, 21'h000000};
      @(posedge clk);
      i_issue <= 1'b0;
      repeat (4) @(posedge clk);
      summarize();
   end
endmodule : cond_branch_exec_unit_tb
